// [src/iobm_top.sv]
// Passive monitor of the serial I/O bus control lines
//
// Notes on behaviour
// - The ident indicator lights briefly on each pass, and a pass in run flags a faulty module.
// - While clear is high, output modules keep their outputs disabled.
// - Clear high while running flags a possibly broken clear line.
// - In run the latch and clock lines toggle and their indicators flash at bus speed.
// - Latch and clock both steady in run flags the bus unit under the monitor as bad.
// - Data and inverted data indicators alternate while data flows.
// - Both data indicators steady in run flags the bus unit under the monitor as bad.
// - The monitor has no address and never drives a bus line.
// - Plugging or pulling the monitor in any state cannot disturb the bus.
`timescale 1ns/1ps
`include "iobm_cfg.svh"
module iobm_top (
   // Clock, reset, enable
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic enable_i,
   // Bus lines, sensed only
   input wire logic ident_i,
   input wire logic clear_i,
   input wire logic latch_i,
   input wire logic bus_clk_i,
   input wire logic data_i,
   input wire logic data_n_i,
   // Controller mode, high in run
   input wire logic run_i,
   // Indicators
   output logic ident_led_o,
   output logic clear_led_o,
   output logic latch_led_o,
   output logic clk_led_o,
   output logic data_led_o,
   output logic data_n_led_o,
   // Fault flags
   output logic fault_module_o,
   output logic fault_clear_o,
   output logic fault_ctrl_o,
   output logic fault_data_o,
   // Gate for outputs of modules fed by this slot
   output logic outputs_off_o
);
   import iobm_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   localparam int NL = 7;
   logic [NL-1:0] raw;
   logic [NL-1:0] s1_ff;
   logic [NL-1:0] s2_ff;
   assign raw = {run_i, data_n_i, data_i, bus_clk_i, latch_i, clear_i, ident_i};

   // Two stages; nothing reads the first but the second
   // Clear stage resets high so module outputs stay disabled until clear is really seen
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         s1_ff <= 7'h02;
         s2_ff <= 7'h02;
      end else if (enable_i) begin
         s1_ff <= raw;
         s2_ff <= s1_ff;
      end
   end

   logic ident_s, clear_s, latch_s, bclk_s, data_s, datan_s, run_s;
   assign {run_s, datan_s, data_s, bclk_s, latch_s, clear_s, ident_s} = s2_ff;

   // ----------------------------------------------------------------
   // Activity classification
   // ----------------------------------------------------------------
   localparam iobm_cnt_t WIN = iobm_cnt_t'(`IOBM_WIN_CYC);
   logic [3:0] act;
   logic [3:0] edg;
   logic [3:0] lines;
   assign lines = {datan_s, data_s, bclk_s, latch_s};

   // One detector per toggling line
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_act
         iobm_act u_act (
            .clock_i(clock_i),
            .reset_i(reset_i),
            .enable_i(enable_i),
            .line_i(lines[g]),
            .window_i(WIN),
            .edge_o(edg[g]),
            .active_o(act[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Ident stretch and mode tracking
   // ----------------------------------------------------------------
   localparam iobm_cnt_t IDW = iobm_cnt_t'(`IOBM_IDENT_CYC);
   iobm_cnt_t id_cnt_ff;
   iobm_mode_t mode_ff;
   logic id_prev_ff;
   logic id_rise;
   assign id_rise = ident_s & ~id_prev_ff;

   // Mode follows the synchronised run input
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         mode_ff <= IOBM_STOPPED;
         id_prev_ff <= 1'b0;
      end else if (enable_i) begin
         mode_ff <= run_s ? IOBM_RUNNING : IOBM_STOPPED;
         id_prev_ff <= ident_s;
      end
   end

   // Stretch short ident pulses so the indicator is visible
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         id_cnt_ff <= '0;
      end else if (enable_i) begin
         if (id_rise) begin
            id_cnt_ff <= IDW;
         end else if (id_cnt_ff != '0) begin
            id_cnt_ff <= id_cnt_ff - iobm_cnt_t'(1);
         end
      end
   end

   // ----------------------------------------------------------------
   // Indicators and faults, all registered
   // ----------------------------------------------------------------
   logic running;
   assign running = (mode_ff == IOBM_RUNNING);

   // Indicators other than ident mirror line levels; run flashing comes from the lines themselves
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         ident_led_o <= 1'b0;
         clear_led_o <= 1'b0;
         latch_led_o <= 1'b0;
         clk_led_o <= 1'b0;
         data_led_o <= 1'b0;
         data_n_led_o <= 1'b0;
         outputs_off_o <= 1'b1;
      end else if (enable_i) begin
         ident_led_o <= ident_s | (id_cnt_ff != '0);
         clear_led_o <= clear_s;
         latch_led_o <= latch_s;
         clk_led_o <= bclk_s;
         data_led_o <= data_s;
         data_n_led_o <= datan_s;
         outputs_off_o <= clear_s;
      end
   end

   // Fault flags: level while the condition holds; module fault is sticky until stop
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         fault_module_o <= 1'b0;
         fault_clear_o <= 1'b0;
         fault_ctrl_o <= 1'b0;
         fault_data_o <= 1'b0;
      end else if (enable_i) begin
         if (running && id_rise) begin
            fault_module_o <= 1'b1;
         end else if (!running) begin
            fault_module_o <= 1'b0;
         end
         fault_clear_o <= running & clear_s;
         fault_ctrl_o <= running & ~act[0] & ~act[1];
         fault_data_o <= running & ~act[2] & ~act[3];
      end
   end

   // No output drives any bus line; the monitor has no address decode.

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_ident_in_run;
      running && id_rise;
   endsequence

   property p_ident_fault;
      @(posedge clock_i) disable iff (reset_i)
      (enable_i and s_ident_in_run) |=> fault_module_o;
   endproperty
   a_ident_fault: assert property (p_ident_fault) else $error("ident in run not flagged");

   property p_ident_led;
      @(posedge clock_i) disable iff (reset_i)
      enable_i && id_rise |=> ident_led_o;
   endproperty
   a_ident_led: assert property (p_ident_led) else $error("ident indicator not lit");

   property p_clear_fault;
      @(posedge clock_i) disable iff (reset_i)
      enable_i |=> (fault_clear_o == $past(running && clear_s));
   endproperty
   a_clear_fault: assert property (p_clear_fault) else $error("clear fault mismatch");

   property p_outputs_off;
      @(posedge clock_i) disable iff (reset_i)
      enable_i && clear_s |=> outputs_off_o;
   endproperty
   a_outputs_off: assert property (p_outputs_off) else $error("outputs not disabled");

   property p_ctrl_fault;
      @(posedge clock_i) disable iff (reset_i)
      fault_ctrl_o |-> $past(running);
   endproperty
   a_ctrl_fault: assert property (p_ctrl_fault) else $error("control fault while stopped");

   property p_ctrl_ok;
      @(posedge clock_i) disable iff (reset_i)
      enable_i && edg[0] ##1 enable_i |=> !fault_ctrl_o;
   endproperty
   a_ctrl_ok: assert property (p_ctrl_ok) else $error("control fault despite toggling");

   property p_data_ok;
      @(posedge clock_i) disable iff (reset_i)
      enable_i && edg[2] ##1 enable_i |=> !fault_data_o;
   endproperty
   a_data_ok: assert property (p_data_ok) else $error("data fault despite toggling");

   property p_data_led;
      @(posedge clock_i) disable iff (reset_i)
      enable_i |=> (data_led_o == $past(data_s) && data_n_led_o == $past(datan_s));
   endproperty
   a_data_led: assert property (p_data_led) else $error("data indicator mismatch");
endmodule

// [src/iobm_cfg.svh]
// Configuration macros for the I/O bus activity monitor
`ifndef IOBM_CFG_SVH
`define IOBM_CFG_SVH
// Clock rate in kHz
`define IOBM_CLK_KHZ 50000
// Observation window in microseconds (line steady if no edge within it)
`define IOBM_WIN_US 1000
// Cycles per microsecond taken first so the product stays inside 32 bits
`define IOBM_WIN_CYC (`IOBM_WIN_US * (`IOBM_CLK_KHZ / 1000))
// Identification indicator stretch in microseconds
`define IOBM_IDENT_US 100000
`define IOBM_IDENT_CYC (`IOBM_IDENT_US * (`IOBM_CLK_KHZ / 1000))
// Counter width for both windows
`define IOBM_CNT_W 24
`endif

// [src/iobm_pkg.sv]
// Types for the I/O bus activity monitor
package iobm_pkg;
   typedef logic [23:0] iobm_cnt_t;
   typedef enum logic [1:0] {IOBM_STOPPED, IOBM_RUNNING} iobm_mode_t;
endpackage

// [src/iobm_act.sv]
// Activity detector for one synchronised bus line
`timescale 1ns/1ps
module iobm_act (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic enable_i,
   // Observed level and window length
   input wire logic line_i,
   input wire logic [23:0] window_i,
   // Classification
   output logic edge_o,
   output logic active_o
);
   logic prev_ff;
   logic [1:0] settle_ff;
   logic [23:0] quiet_ff;

   // Edges ignored until the synchroniser holds real levels; avoids a false edge after reset
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         settle_ff <= 2'h0;
      end else if (enable_i && settle_ff != 2'h3) begin
         settle_ff <= settle_ff + 2'h1;
      end
   end

   // Previous level for edge finding
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         prev_ff <= 1'b0;
      end else if (enable_i) begin
         prev_ff <= line_i;
      end
   end

   assign edge_o = (settle_ff == 2'h3) & (prev_ff != line_i);

   // Quiet counter restarts on each edge, saturates at the window
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         quiet_ff <= 24'h000000;
         active_o <= 1'b0;
      end else if (enable_i) begin
         if (edge_o) begin
            quiet_ff <= 24'h000000;
            active_o <= 1'b1;
         end else if (quiet_ff >= window_i) begin
            active_o <= 1'b0;
         end else begin
            quiet_ff <= quiet_ff + 24'h000001;
         end
      end
   end
endmodule

// [verif/iobm_cpu_model.sv]
// Controller model that drives the serial I/O bus lines
`timescale 1ns/1ps
module iobm_cpu_model (
   // Commands from the bench
   input wire logic run_req_i,
   input wire logic traffic_i,
   input wire logic ident_req_i,
   input wire logic bad_clear_i,
   // Bus lines
   output logic ident_o,
   output logic clear_o,
   output logic latch_o,
   output logic bus_clk_o,
   output logic data_o,
   output logic data_n_o
);
   // Idle levels; the bus clock stands still outside frames
   initial begin
      {ident_o, latch_o, bus_clk_o, data_o} = 4'h0;
      data_n_o = 1'b1;
   end
   // Clear high only while stopped, unless a broken line is commanded
   assign clear_o = !run_req_i || bad_clear_i;
   // Ident pass on each stop-to-run change and on a module-set change
   always @(posedge run_req_i or posedge ident_req_i) begin
      ident_o = 1'b1;
      #1000 ident_o = 1'b0;
   end
   // Frames of eight bits; frame length keeps edges off the sampling edge
   always begin
      wait (traffic_i && run_req_i);
      #3 latch_o = !latch_o;
      for (int i = 0; i < 8; i++) begin
         data_o = i[0];
         data_n_o = !i[0];
         #80 bus_clk_o = 1'b1;
         #80 bus_clk_o = 1'b0;
      end
      #37;
   end
endmodule

// [verif/tb.sv]
// Self-checking bench for the I/O bus activity monitor
`timescale 1ns/1ps
module tb;
   // ----------
   // Signals
   // ----------
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic enable_i = 1'b0;
   logic run_req = 1'b0, traffic = 1'b0, ident_req = 1'b0, bad_clear = 1'b0;
   logic ident, clear, latch, bus_clk, data, data_n;
   logic ident_led_o, clear_led_o, latch_led_o, clk_led_o, data_led_o, data_n_led_o;
   logic fault_module_o, fault_clear_o, fault_ctrl_o, fault_data_o, outputs_off_o;
   int mismatches = 0;
   int num_checks = 0;
   wire logic [7:0] obs = {fault_module_o, fault_clear_o, fault_ctrl_o, fault_data_o,
      outputs_off_o, ident_led_o, clear_led_o, latch_led_o};
   // Free-running 50 MHz clock
   always #10 clock_i = !clock_i;
   iobm_cpu_model cpu (.run_req_i(run_req), .traffic_i(traffic), .ident_req_i(ident_req),
      .bad_clear_i(bad_clear), .ident_o(ident), .clear_o(clear), .latch_o(latch),
      .bus_clk_o(bus_clk), .data_o(data), .data_n_o(data_n));
   iobm_top dut (.clock_i, .reset_i, .enable_i, .ident_i(ident), .clear_i(clear), .latch_i(latch),
      .bus_clk_i(bus_clk), .data_i(data), .data_n_i(data_n), .run_i(run_req), .ident_led_o,
      .clear_led_o, .latch_led_o, .clk_led_o, .data_led_o, .data_n_led_o, .fault_module_o,
      .fault_clear_o, .fault_ctrl_o, .fault_data_o, .outputs_off_o);
   // ----------
   // Tasks
   // ----------
   task automatic check(input string name, input logic seen, input logic exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %b seen %b", name, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Bounded wait on one observed output; a timeout ends the run
   task automatic wait_bit(input string name, input int idx, input logic val, input int max);
      int n = 0;
      // Look first on a falling edge, clear of the edge that launches outputs
      @(negedge clock_i);
      while (obs[idx] !== val && n < max) begin
         @(negedge clock_i);
         n++;
      end
      check(name, obs[idx], val);
      if (obs[idx] !== val) test_done();
   endtask
   task automatic pulse_ident();
      @(posedge clock_i);
      ident_req <= 1'b1;
      @(posedge clock_i);
      ident_req <= 1'b0;
   endtask
   // Stopped: clear shown, no faults even with an ident pass
   task automatic t_stopped();
      wait_bit("outputs_off_o", 3, 1'b1, 10);
      wait_bit("clear_led_o", 1, 1'b1, 10);
      pulse_ident();
      repeat (100) @(negedge clock_i);
      check("ident_led_o", ident_led_o, 1'b1);
      check("fault_module_o", fault_module_o, 1'b0);
      check("fault_ctrl_o", fault_ctrl_o, 1'b0);
      check("fault_data_o", fault_data_o, 1'b0);
      check("fault_clear_o", fault_clear_o, 1'b0);
      $display("test stopped done");
   endtask
   // Running with a silent bus flags both unit faults at once
   task automatic t_run_quiet();
      @(posedge clock_i);
      run_req <= 1'b1;
      wait_bit("outputs_off_o", 3, 1'b0, 10);
      wait_bit("fault_ctrl_o", 5, 1'b1, 10);
      wait_bit("fault_data_o", 4, 1'b1, 10);
      check("fault_clear_o", fault_clear_o, 1'b0);
      $display("test run_quiet done");
   endtask
   // Traffic: indicators flash, data pair alternates, faults clear
   task automatic t_traffic();
      int nl = 0, nc = 0, nd = 0, eq = 0;
      logic pl, pc, pd;
      @(posedge clock_i);
      traffic <= 1'b1;
      wait_bit("fault_ctrl_o", 5, 1'b0, 300);
      wait_bit("fault_data_o", 4, 1'b0, 300);
      pl = latch_led_o;
      pc = clk_led_o;
      pd = data_led_o;
      repeat (3000) begin
         @(negedge clock_i);
         nl += (latch_led_o !== pl);
         nc += (clk_led_o !== pc);
         nd += (data_led_o !== pd);
         eq += (data_led_o === data_n_led_o);
         pl = latch_led_o;
         pc = clk_led_o;
         pd = data_led_o;
      end
      check("latch_flash", nl > 10, 1'b1);
      check("clk_flash", nc > 100, 1'b1);
      check("data_alt", nd > 50 && eq == 0, 1'b1);
      $display("test traffic done");
   endtask
   // Clear stuck high in run
   task automatic t_bad_clear();
      @(posedge clock_i);
      bad_clear <= 1'b1;
      wait_bit("fault_clear_o", 6, 1'b1, 10);
      check("outputs_off_o", outputs_off_o, 1'b1);
      @(posedge clock_i);
      bad_clear <= 1'b0;
      wait_bit("fault_clear_o", 6, 1'b0, 10);
      $display("test bad_clear done");
   endtask
   // Ident pass in run flags a module until the controller stops
   task automatic t_ident_run();
      pulse_ident();
      wait_bit("fault_module_o", 7, 1'b1, 20);
      @(posedge clock_i);
      run_req <= 1'b0;
      wait_bit("fault_module_o", 7, 1'b0, 10);
      wait_bit("outputs_off_o", 3, 1'b1, 10);
      $display("test ident_run done");
   endtask
   // Traffic stops in run: faults only after the full window
   task automatic t_steady();
      @(posedge clock_i);
      run_req <= 1'b1;
      wait_bit("fault_ctrl_o", 5, 1'b0, 300);
      @(posedge clock_i);
      traffic <= 1'b0;
      repeat (49000) @(negedge clock_i);
      check("fault_ctrl_o", fault_ctrl_o, 1'b0);
      wait_bit("fault_ctrl_o", 5, 1'b1, 1200);
      wait_bit("fault_data_o", 4, 1'b1, 10);
      $display("test steady done");
   endtask
   // Main sequence: reset for 10 cycles, then the scenarios
   initial begin
      repeat (4) @(negedge clock_i);
      check("outputs_off_o", outputs_off_o, 1'b1);
      check("fault_ctrl_o", fault_ctrl_o, 1'b0);
      repeat (6) @(posedge clock_i);
      reset_i <= 1'b0;
      enable_i <= 1'b1;
      t_stopped();
      t_run_quiet();
      t_traffic();
      t_bad_clear();
      t_ident_run();
      t_steady();
      test_done();
   end
endmodule
